// [logic/periph_irq_map.vh]
// Purpose: Register map, field positions and reset values of the
//          host bus front end and vectored interrupt controller.
// Assumes: Included by bare name; definitions only.
// Notes:   Indexes 0..15 are direct addresses, 16..23 are the
//          indirect registers (16 plus the indirect index).
`ifndef PERIPH_IRQ_MAP_VH
`define PERIPH_IRQ_MAP_VH

// ------------------------------------------------------------------
// Direct register addresses
// ------------------------------------------------------------------
`define ADR_INDIRECT_DATA    4'h0
`define ADR_GENERAL_IO       4'h1
`define ADR_PEND_LOW         4'h2
`define ADR_PEND_HIGH        4'h3
`define ADR_INSVC_LOW        4'h4
`define ADR_INSVC_HIGH       4'h5
`define ADR_MASK_LOW         4'h6
`define ADR_MASK_HIGH        4'h7
`define ADR_POINTER_VECTOR   4'h8
`define ADR_TIMER_AB_CTRL    4'h9
`define ADR_TIMER_B_COUNT    4'ha
`define ADR_TIMER_A_COUNT    4'hb
`define ADR_SERIAL_CTRL      4'hc
`define ADR_RX_STATE         4'hd
`define ADR_TX_STATE         4'he
`define ADR_SERIAL_DATA      4'hf

// ------------------------------------------------------------------
// Unified storage indexes
// ------------------------------------------------------------------
`define REG_COUNT            24
`define IDX_INDIRECT_BASE    5'h10
`define IDX_SYNC_PATTERN     5'h10
`define IDX_TIMER_D_COUNT    5'h11
`define IDX_TIMER_C_COUNT    5'h12
`define IDX_EDGE_POLARITY    5'h13
`define IDX_ENABLE_LOW       5'h14
`define IDX_ENABLE_HIGH      5'h15
`define IDX_LINE_DIRECTION   5'h16
`define IDX_TIMER_CD_CTRL    5'h17

// Registers kept through reset (timer counts and serial data)
`define KEEP_ON_RESET        24'h068c00

// ------------------------------------------------------------------
// Pointer/vector register fields
// ------------------------------------------------------------------
`define PVR_BASE_HI          7
`define PVR_BASE_LO          5
`define PVR_INSVC_EN_BIT     3
`define PVR_INDEX_HI         2
`define PVR_INDEX_LO         0

// ------------------------------------------------------------------
// Channels, reset values and opcodes
// ------------------------------------------------------------------
`define CH_PERIPH_MASK       16'h3f30
`define REG_RESET_VALUE      8'h00
`define IRQ_RESET_VALUE      16'h0000
`define OPC_RETURN_PREFIX    8'hed
`define OPC_RETURN_SUFFIX    8'h4d

`endif

// [logic/pin_filter.v]
// Purpose: Three-stage synchroniser with agreement filter for pins.
// Assumes: One clock; synchronous active-low reset.
// Notes:   The output follows only when stages two and three agree.
`timescale 1ns/1ps

module pin_filter #(
  parameter             WIDTH = 1,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] level
);

  reg [WIDTH-1:0] st1_r;
  reg [WIDTH-1:0] st2_r;
  reg [WIDTH-1:0] st3_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      st1_r <= INIT;
      st2_r <= INIT;
      st3_r <= INIT;
    end else begin
      st1_r <= pin_in;
      st2_r <= st1_r;
      st3_r <= st2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : agree
      always @(posedge clk) begin
        if (!rst_n) begin
          level[g] <= INIT[g];
        end else if (st2_r[g] == st3_r[g]) begin
          level[g] <= st3_r[g];
        end
      end
    end
  endgenerate

endmodule

// [logic/prio_pick.v]
// Purpose: Picks the highest numbered active channel of sixteen.
// Assumes: Channel number equals priority rank, 15 highest.
// Notes:   Purely combinational.
`timescale 1ns/1ps

module prio_pick (
  input  wire [15:0] req,
  output reg         any,
  output reg  [3:0]  code
);

  integer i;

  always @* begin
    any  = 1'b0;
    code = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      if (req[i]) begin
        any  = 1'b1;
        code = i[3:0];
      end
    end
  end

endmodule

// [logic/periph_irq_top.v]
// Purpose: Host bus front end and vectored interrupt controller of a
//          multifunction peripheral with sixteen channels.
// Assumes: SYS_CLK at 50 MHz samples all bus pins; peripheral events
//          arrive as one-cycle pulses on the same clock.
// Notes:   Timer and serial behaviour is outside; only their
//          registers are held here.
//
// Operation
// - Reset clears registers except timer/serial data
// - Acknowledge is request low with first-cycle low
// - Read is select AND read strobe
// - Data bus tri-state except read or acknowledge
// - Write captured when first strobe goes inactive
// - Sixteen direct registers at addresses 0..F
// - Eight indirect registers through index and window
// - Indirect access never changes the index
// - Vector: base bits, channel code, bit0 zero
// - Channel code equals priority rank
// - Enable bit gates setting of pending
// - Enabled channel event sets pending bit
// - Masked pending stays pending, not presented
// - Supplying vector clears channel pending bit
// - In-service enable sets in-service on vector
// - Return opcode pair clears active in-service
// - In-service bits clearable by register write
// - Request output is active-low open drain
// - Fixed channel priority, line seven highest
// - Pending write: zero clears, one keeps
// - Mask bit one unmasks, zero masks
`timescale 1ns/1ps
`include "periph_irq_map.vh"

module periph_irq_top (
  input  wire        SYS_CLK,
  input  wire        NRST,
  input  wire        CHIP_SEL_N,
  input  wire        READ_N,
  input  wire        WRITE_N,
  input  wire [3:0]  ADDR,
  input  wire [7:0]  DATA_IN,
  output reg  [7:0]  DATA_OUT,
  output reg         DATA_OE_N,
  input  wire        IO_REQUEST_N,
  input  wire        FIRST_CYCLE_N,
  input  wire        CHAIN_ENABLE_IN,
  output reg         CHAIN_ENABLE_OUT,
  output reg         INT_N_OUT,
  output reg         INT_N_OE_N,
  input  wire [7:0]  IO_IN,
  output reg  [7:0]  IO_OUT,
  output reg  [7:0]  IO_OE_N,
  input  wire [15:0] PERIPH_EVENT
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire       ce_n;
  wire       rd_n;
  wire       wr_n;
  wire       io_request_n_n;
  wire       m1_n;
  wire       chain_in;
  wire [3:0] adr;
  wire [7:0] dat;
  wire [7:0] io_lvl;

  pin_filter #(
    .WIDTH (14),
    .INIT  (14'h3f00)
  ) u_ctl_filter (
    .clk    (SYS_CLK),
    .rst_n  (NRST),
    .pin_in ({CHIP_SEL_N, READ_N, WRITE_N, IO_REQUEST_N, FIRST_CYCLE_N,
              CHAIN_ENABLE_IN, ADDR, DATA_IN[3:0]}),
    .level  ({ce_n, rd_n, wr_n, io_request_n_n, m1_n, chain_in, adr, dat[3:0]})
  );

  pin_filter #(
    .WIDTH (12),
    .INIT  (12'h000)
  ) u_dat_filter (
    .clk    (SYS_CLK),
    .rst_n  (NRST),
    .pin_in ({DATA_IN[7:4], IO_IN}),
    .level  ({dat[7:4], io_lvl})
  );

  // ----------------------------------------------------------------
  // Bus cycle decode
  // ----------------------------------------------------------------
  function [4:0] reg_index;
    input [3:0] a;
    input [2:0] ia;
    begin
      if (a == `ADR_INDIRECT_DATA) begin
        reg_index = `IDX_INDIRECT_BASE | {2'b00, ia};
      end else begin
        reg_index = {1'b0, a};
      end
    end
  endfunction

  wire rd_act    = ~ce_n & ~rd_n;
  wire wr_act    = ~ce_n & ~wr_n;
  wire ack_act   = ~io_request_n_n & ~m1_n;
  wire fetch_act = ~m1_n & ~rd_n & io_request_n_n;

  reg        wr_act_r;
  reg        ack_act_r;
  reg        fetch_act_r;
  reg [7:0]  wr_data_r;
  reg [3:0]  wr_adr_r;
  reg [7:0]  fetch_byte_r;
  reg        prev_prefix_r;

  wire wr_end    = wr_act_r & ~wr_act;
  wire ack_start = ack_act & ~ack_act_r;
  wire fetch_end = fetch_act_r & ~fetch_act;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg  [7:0]  store_r [0:`REG_COUNT-1];
  reg  [15:0] pend_r;
  reg  [15:0] insvc_r;
  reg  [7:0]  vec_r;
  reg         ack_ours_r;
  reg  [7:0]  io_prev_r;

  wire [7:0]  pointer_and_vector_base      = store_r[`ADR_POINTER_VECTOR];
  wire [2:0]  ind_idx  = pointer_and_vector_base[`PVR_INDEX_HI:`PVR_INDEX_LO];
  wire [4:0]  wr_idx   = reg_index(wr_adr_r, ind_idx);
  wire [4:0]  rd_idx   = reg_index(adr, ind_idx);
  wire [15:0] mask     = {store_r[`ADR_MASK_HIGH], store_r[`ADR_MASK_LOW]};
  wire [15:0] enable   = {store_r[`IDX_ENABLE_HIGH],
                          store_r[`IDX_ENABLE_LOW]};
  wire [7:0]  ddr      = store_r[`IDX_LINE_DIRECTION];
  wire [7:0]  polarity = store_r[`IDX_EDGE_POLARITY];

  // ----------------------------------------------------------------
  // Channel events
  // ----------------------------------------------------------------
  // Input lines raise events on the edge chosen by the polarity bits.
  wire [7:0]  io_rise = io_lvl & ~io_prev_r;
  wire [7:0]  io_fall = ~io_lvl & io_prev_r;
  wire [7:0]  io_edge = (polarity & io_rise) | (~polarity & io_fall);
  wire [15:0] events  = (PERIPH_EVENT & `CH_PERIPH_MASK) |
                        {io_edge[7:6], 6'h00, io_edge[5:4], 2'h0,
                         io_edge[3:0]};

  // ----------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------
  wire       req_any;
  wire [3:0] req_code;
  wire       svc_any;
  wire [3:0] svc_code;

  prio_pick u_req_pick (
    .req  (pend_r & mask),
    .any  (req_any),
    .code (req_code)
  );

  prio_pick u_svc_pick (
    .req  (insvc_r),
    .any  (svc_any),
    .code (svc_code)
  );

  // ----------------------------------------------------------------
  // Interrupt state next values
  // ----------------------------------------------------------------
  reg  [15:0] pend_keep;
  reg  [15:0] insvc_keep;
  reg  [15:0] ack_bit;
  reg         ack_take;
  reg         reti_hit;
  reg  [15:0] reti_bit;
  reg  [15:0] pend_nxt;
  reg  [15:0] insvc_nxt;

  always @* begin
    pend_keep  = 16'hffff;
    insvc_keep = 16'hffff;
    if (wr_end) begin
      // Writing zero clears, one leaves the bit as it is
      case (wr_adr_r)
        `ADR_PEND_LOW:   pend_keep[7:0]   = wr_data_r;
        `ADR_PEND_HIGH:  pend_keep[15:8]  = wr_data_r;
        `ADR_INSVC_LOW:  insvc_keep[7:0]  = wr_data_r;
        `ADR_INSVC_HIGH: insvc_keep[15:8] = wr_data_r;
        default:         pend_keep        = 16'hffff;
      endcase
    end
    ack_take = ack_start & chain_in & req_any;
    ack_bit  = ack_take ? (16'h0001 << req_code) : 16'h0000;
    reti_hit = fetch_end & prev_prefix_r &
               (fetch_byte_r == `OPC_RETURN_SUFFIX);
    reti_bit = (reti_hit & svc_any) ? (16'h0001 << svc_code) : 16'h0000;
    // New events win over any clear in the same cycle
    pend_nxt  = (pend_r & pend_keep & ~ack_bit) |
                (events & enable);
    insvc_nxt = (insvc_r & insvc_keep & ~reti_bit) |
                (pointer_and_vector_base[`PVR_INSVC_EN_BIT] ? ack_bit : 16'h0000);
  end

  // ----------------------------------------------------------------
  // Strobe tracking and write capture
  // ----------------------------------------------------------------
  // Data and address are sampled all through the strobe and the last
  // sample is committed at its end, so late data still lands.
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      wr_act_r      <= 1'b0;
      ack_act_r     <= 1'b0;
      fetch_act_r   <= 1'b0;
      wr_data_r     <= 8'h00;
      wr_adr_r      <= 4'h0;
      fetch_byte_r  <= 8'h00;
      prev_prefix_r <= 1'b0;
      io_prev_r     <= 8'h00;
    end else begin
      wr_act_r    <= wr_act;
      ack_act_r   <= ack_act;
      fetch_act_r <= fetch_act;
      io_prev_r   <= io_lvl;
      if (wr_act) begin
        wr_data_r <= dat;
        wr_adr_r  <= adr;
      end
      if (fetch_act) begin
        fetch_byte_r <= dat;
      end
      if (fetch_end) begin
        prev_prefix_r <= (fetch_byte_r == `OPC_RETURN_PREFIX);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file writes
  // ----------------------------------------------------------------
  integer k;

  always @(posedge SYS_CLK) begin
    for (k = 0; k < `REG_COUNT; k = k + 1) begin
      if (!NRST) begin
        if (((`KEEP_ON_RESET >> k) & 24'h000001) == 24'h000000) begin
          store_r[k] <= `REG_RESET_VALUE;
        end
      end else if (wr_end && wr_idx == k[4:0]) begin
        store_r[k] <= wr_data_r;
      end
    end
  end

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      pend_r  <= `IRQ_RESET_VALUE;
      insvc_r <= `IRQ_RESET_VALUE;
    end else begin
      pend_r  <= pend_nxt;
      insvc_r <= insvc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  reg [7:0] rd_value;

  always @* begin
    case (rd_idx)
      {1'b0, `ADR_GENERAL_IO}:
        rd_value = (ddr & store_r[`ADR_GENERAL_IO]) | (~ddr & io_lvl);
      {1'b0, `ADR_PEND_LOW}:   rd_value = pend_r[7:0];
      {1'b0, `ADR_PEND_HIGH}:  rd_value = pend_r[15:8];
      {1'b0, `ADR_INSVC_LOW}:  rd_value = insvc_r[7:0];
      {1'b0, `ADR_INSVC_HIGH}: rd_value = insvc_r[15:8];
      default:                 rd_value = store_r[rd_idx];
    endcase
  end

  // ----------------------------------------------------------------
  // Acknowledge and bus drive
  // ----------------------------------------------------------------
  // The vector is frozen at the start of the cycle so a new event
  // during acknowledge cannot change what the processor reads.
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      ack_ours_r <= 1'b0;
      vec_r      <= 8'h00;
      DATA_OUT   <= 8'h00;
      DATA_OE_N  <= 1'b1;
    end else begin
      if (ack_take) begin
        ack_ours_r <= 1'b1;
        vec_r      <= {pointer_and_vector_base[`PVR_BASE_HI:`PVR_BASE_LO], req_code,
                       1'b0};
      end else if (!ack_act) begin
        ack_ours_r <= 1'b0;
      end
      if (ack_take) begin
        DATA_OUT  <= {pointer_and_vector_base[`PVR_BASE_HI:`PVR_BASE_LO], req_code, 1'b0};
        DATA_OE_N <= 1'b0;
      end else if (ack_ours_r && ack_act) begin
        DATA_OUT  <= vec_r;
        DATA_OE_N <= 1'b0;
      end else if (rd_act) begin
        DATA_OUT  <= rd_value;
        DATA_OE_N <= 1'b0;
      end else begin
        DATA_OE_N <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request, chain and I/O line outputs
  // ----------------------------------------------------------------
  // A shared request line is only ever pulled low, never driven high.
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      INT_N_OUT        <= 1'b0;
      INT_N_OE_N       <= 1'b1;
      CHAIN_ENABLE_OUT <= 1'b0;
      IO_OUT           <= 8'h00;
      IO_OE_N          <= 8'hff;
    end else begin
      INT_N_OUT        <= 1'b0;
      INT_N_OE_N       <= ~(chain_in & req_any);
      CHAIN_ENABLE_OUT <= chain_in & ~req_any & ~(|insvc_r) &
                          ~ack_ours_r;
      IO_OUT           <= store_r[`ADR_GENERAL_IO];
      IO_OE_N          <= ~ddr;
    end
  end

endmodule

// [testbench/periph_irq_sva.sv]
// Purpose: Port-level checks of the bus front end and interrupt logic.
// Assumes: Pins pass a four-edge filter before the core sees them.
// Notes:   Each bound carries at least one spare cycle over the filter delay.
`timescale 1ns/1ps

module periph_irq_sva (
  input wire       SYS_CLK,
  input wire       NRST,
  input wire       CHIP_SEL_N,
  input wire       READ_N,
  input wire       WRITE_N,
  input wire       IO_REQUEST_N,
  input wire       FIRST_CYCLE_N,
  input wire       CHAIN_ENABLE_IN,
  input wire       CHAIN_ENABLE_OUT,
  input wire       INT_N_OUT,
  input wire       INT_N_OE_N,
  input wire       DATA_OE_N,
  input wire [7:0] DATA_OUT,
  input wire [7:0] IO_OE_N
);
  reg  [3:0] idle_r;
  reg  [3:0] ce_hi_r;
  wire       idle;

  assign idle = (CHIP_SEL_N | READ_N) & (IO_REQUEST_N | FIRST_CYCLE_N);

  // Saturating run lengths of bus idle and chip select high
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      idle_r  <= 4'h0;
      ce_hi_r <= 4'h0;
    end else begin
      idle_r  <= !idle ? 4'h0 : (idle_r == 4'hf ? idle_r : idle_r + 4'h1);
      ce_hi_r <= !CHIP_SEL_N ? 4'h0 :
                 (ce_hi_r == 4'hf ? ce_hi_r : ce_hi_r + 4'h1);
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  a_reset_outputs: assert property (disable iff (1'b0)
    !NRST |=> DATA_OE_N && INT_N_OE_N && IO_OE_N == 8'hff
              && !CHAIN_ENABLE_OUT)
    else $error("Outputs not at reset state");
  a_bus_idle_float: assert property (idle_r >= 4'h7 |-> DATA_OE_N)
    else $error("Data bus driven outside read or acknowledge");
  a_read_drives_bus: assert property (
    (!CHIP_SEL_N && !READ_N) [*7] |-> !DATA_OE_N)
    else $error("Read did not drive the data bus");
  a_write_quiet_bus: assert property (
    (!CHIP_SEL_N && !WRITE_N && READ_N && IO_REQUEST_N) [*8] |-> DATA_OE_N)
    else $error("Data bus driven during a write");
  a_vector_even: assert property (
    (!DATA_OE_N && ce_hi_r >= 4'h7) |-> !DATA_OUT[0])
    else $error("Acknowledge vector is odd");
  a_request_open_drain: assert property (INT_N_OUT == 1'b0)
    else $error("Request pin drives a high level");
  a_chain_gates_req: assert property (
    (!CHAIN_ENABLE_IN) [*7] |-> INT_N_OE_N && !CHAIN_ENABLE_OUT)
    else $error("Request or chain out active with chain in low");
  a_chain_blocked: assert property (
    (!INT_N_OE_N) [*2] |-> !CHAIN_ENABLE_OUT)
    else $error("Chain out high while requesting");
endmodule

bind periph_irq_top periph_irq_sva chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .CHIP_SEL_N(CHIP_SEL_N),
  .READ_N(READ_N), .WRITE_N(WRITE_N), .IO_REQUEST_N(IO_REQUEST_N),
  .FIRST_CYCLE_N(FIRST_CYCLE_N), .CHAIN_ENABLE_IN(CHAIN_ENABLE_IN),
  .CHAIN_ENABLE_OUT(CHAIN_ENABLE_OUT), .INT_N_OUT(INT_N_OUT),
  .INT_N_OE_N(INT_N_OE_N), .DATA_OE_N(DATA_OE_N), .DATA_OUT(DATA_OUT),
  .IO_OE_N(IO_OE_N));

// [testbench/cpu_model.sv]
// Purpose: Processor side of the strobe bus and acknowledge cycle.
// Assumes: Strobes held well past the four-edge pin filter.
// Notes:   A floating bus shows a value that changes every cycle.
`timescale 1ns/1ps

module cpu_model (
  input  wire       clk,
  input  wire [7:0] dev_data,
  input  wire       dev_oe_n,
  output reg        cs_n,
  output reg        rd_n,
  output reg        wr_n,
  output reg        io_request_n_n,
  output reg        m1_n,
  output reg  [3:0] adr,
  output wire [7:0] bus
);
  reg [7:0] hval;
  reg       hdrv;
  reg [7:0] last;

  assign bus = !dev_oe_n ? dev_data : (hdrv ? hval : ~last);

  always @(posedge clk) last <= bus;

  initial begin
    {cs_n, rd_n, wr_n, io_request_n_n, m1_n, hdrv} = 6'h3e;
    adr  = 4'h0;
    hval = 8'h00;
    last = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Address and data stay put until well after the strobes rise
  task automatic wr(input [3:0] a, input [7:0] v);
    tick(1);
    adr  = a;
    hval = v;
    hdrv = 1'b1;
    {cs_n, wr_n} = 2'b00;
    tick(8);
    {cs_n, wr_n} = 2'b11;
    tick(8);
    hdrv = 1'b0;
  endtask

  task automatic rd(input [3:0] a, output [7:0] v, output oe);
    tick(1);
    adr = a;
    {cs_n, rd_n} = 2'b00;
    tick(8);
    v  = dev_data;
    oe = dev_oe_n;
    {cs_n, rd_n} = 2'b11;
    tick(8);
  endtask

  task automatic ack(output [7:0] v, output oe);
    tick(1);
    {io_request_n_n, m1_n} = 2'b00;
    tick(8);
    v  = dev_data;
    oe = dev_oe_n;
    {io_request_n_n, m1_n} = 2'b11;
    tick(8);
  endtask

  task automatic fetch(input [7:0] op);
    tick(1);
    hval = op;
    hdrv = 1'b1;
    {m1_n, rd_n} = 2'b00;
    tick(6);
    {m1_n, rd_n} = 2'b11;
    tick(2);
    hdrv = 1'b0;
    tick(4);
  endtask
endmodule

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the bus front end and interrupts.
// Assumes: Host pins come from cpu_model one ns after each edge.
// Notes:   Expected values follow the register map and vector format.
`timescale 1ns/1ps
`include "periph_irq_map.vh"
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
  end \
end

module tb_top;
  reg         SYS_CLK;
  reg         NRST;
  reg         CHAIN_ENABLE_IN;
  reg  [7:0]  IO_IN;
  reg  [15:0] PERIPH_EVENT;
  wire        CHIP_SEL_N, READ_N, WRITE_N, IO_REQUEST_N, FIRST_CYCLE_N;
  wire [3:0]  ADDR;
  wire [7:0]  DATA_IN, DATA_OUT, IO_OUT, IO_OE_N;
  wire        DATA_OE_N, CHAIN_ENABLE_OUT, INT_N_OUT, INT_N_OE_N;
  wire        int_line;
  int         bad_count = 0;
  int         compares = 0;
  reg  [7:0]  d;
  reg         oe;
  reg  [7:0]  top_bits = 8'ha8;
  logic [3:0] rw [7] = '{4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'hf};
  logic [3:0] codes [4] = '{4'hd, 4'h8, 4'h5, 4'h4};
  logic [7:0] line_vec [3] = '{8'hbe, 8'hbc, 8'hae};

  // Shared request line with a pull-up
  assign int_line = INT_N_OE_N ? 1'b1 : INT_N_OUT;

  periph_irq_top DUT (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .CHIP_SEL_N(CHIP_SEL_N),
    .READ_N(READ_N), .WRITE_N(WRITE_N), .ADDR(ADDR), .DATA_IN(DATA_IN),
    .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
    .IO_REQUEST_N(IO_REQUEST_N), .FIRST_CYCLE_N(FIRST_CYCLE_N),
    .CHAIN_ENABLE_IN(CHAIN_ENABLE_IN), .CHAIN_ENABLE_OUT(CHAIN_ENABLE_OUT),
    .INT_N_OUT(INT_N_OUT), .INT_N_OE_N(INT_N_OE_N), .IO_IN(IO_IN),
    .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N), .PERIPH_EVENT(PERIPH_EVENT));

  cpu_model cpu (
    .clk(SYS_CLK), .dev_data(DATA_OUT), .dev_oe_n(DATA_OE_N),
    .cs_n(CHIP_SEL_N), .rd_n(READ_N), .wr_n(WRITE_N),
    .io_request_n_n(IO_REQUEST_N), .m1_n(FIRST_CYCLE_N), .adr(ADDR), .bus(DATA_IN));

  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  task automatic rchk(input [3:0] a, input [7:0] e);
    cpu.rd(a, d, oe);
    `CHK(oe, 1'b0)
    `CHK(d, e)
  endtask

  task automatic iwr(input [2:0] i, input [7:0] v);
    cpu.wr(`ADR_POINTER_VECTOR, top_bits | {5'h00, i});
    cpu.wr(`ADR_INDIRECT_DATA, v);
  endtask

  task automatic ev(input [15:0] m);
    @(posedge SYS_CLK) #1 PERIPH_EVENT = m;
    @(posedge SYS_CLK) #1 PERIPH_EVENT = 16'h0000;
    cpu.tick(4);
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge SYS_CLK);
    bad_count++;
    give_verdict();
  end

  initial begin
    {NRST, CHAIN_ENABLE_IN, IO_IN, PERIPH_EVENT} = 26'h1000000;
    // Four edges: the pin filters are reset too
    cpu.tick(4);
    NRST = 1'b1;
    cpu.tick(4);
    for (int a = 0; a < 15; a++)
      if (a < 10 || a > 11) rchk(a[3:0], 8'h00);
    `CHK(IO_OE_N, 8'hff)
    `CHK(int_line, 1'b1)
    for (int k = 0; k < 7; k++) cpu.wr(rw[k], {rw[k], ~rw[k]});
    for (int k = 0; k < 7; k++) rchk(rw[k], {rw[k], ~rw[k]});
    cpu.wr(`ADR_MASK_LOW, 8'h00);
    cpu.wr(`ADR_MASK_HIGH, 8'h00);
    for (int i = 0; i < 8; i++) iwr(i[2:0], 8'h40 | i[7:0]);
    `CHK(IO_OE_N, 8'hb9)
    for (int i = 0; i < 8; i++) begin
      cpu.wr(`ADR_POINTER_VECTOR, top_bits | i[7:0]);
      rchk(`ADR_INDIRECT_DATA, 8'h40 | i[7:0]);
      rchk(`ADR_INDIRECT_DATA, 8'h40 | i[7:0]);
      rchk(`ADR_POINTER_VECTOR, top_bits | i[7:0]);
    end
    for (int i = 3; i < 7; i++) iwr(i[2:0], 8'h00);
    ev(16'h2000);
    rchk(`ADR_PEND_HIGH, 8'h00);
    iwr(3'h5, 8'hff);
    iwr(3'h4, 8'hff);
    ev(16'h2130);
    rchk(`ADR_PEND_HIGH, 8'h21);
    rchk(`ADR_PEND_LOW, 8'h30);
    `CHK(int_line, 1'b1)
    cpu.wr(`ADR_MASK_HIGH, 8'hff);
    cpu.wr(`ADR_MASK_LOW, 8'hff);
    `CHK(int_line, 1'b0)
    `CHK(CHAIN_ENABLE_OUT, 1'b0)
    for (int k = 0; k < 4; k++) begin
      cpu.ack(d, oe);
      `CHK(oe, 1'b0)
      `CHK(d, {3'h5, codes[k], 1'b0})
    end
    cpu.ack(d, oe);
    `CHK(oe, 1'b1)
    rchk(`ADR_PEND_HIGH, 8'h00);
    rchk(`ADR_PEND_LOW, 8'h00);
    rchk(`ADR_INSVC_HIGH, 8'h21);
    rchk(`ADR_INSVC_LOW, 8'h30);
    cpu.fetch(`OPC_RETURN_PREFIX);
    cpu.fetch(`OPC_RETURN_SUFFIX);
    rchk(`ADR_INSVC_HIGH, 8'h01);
    cpu.wr(`ADR_INSVC_HIGH, 8'hfe);
    cpu.wr(`ADR_INSVC_LOW, 8'hef);
    rchk(`ADR_INSVC_HIGH, 8'h00);
    rchk(`ADR_INSVC_LOW, 8'h20);
    ev(16'h0600);
    cpu.wr(`ADR_PEND_HIGH, 8'hfb);
    rchk(`ADR_PEND_HIGH, 8'h02);
    CHAIN_ENABLE_IN = 1'b0;
    cpu.tick(8);
    `CHK(int_line, 1'b1)
    CHAIN_ENABLE_IN = 1'b1;
    cpu.wr(`ADR_MASK_HIGH, 8'hfd);
    `CHK(int_line, 1'b1)
    rchk(`ADR_PEND_HIGH, 8'h02);
    cpu.wr(`ADR_MASK_HIGH, 8'hff);
    `CHK(int_line, 1'b0)
    cpu.ack(d, oe);
    `CHK(d, 8'hb2)
    cpu.wr(`ADR_INSVC_HIGH, 8'h00);
    cpu.wr(`ADR_INSVC_LOW, 8'h00);
    `CHK(CHAIN_ENABLE_OUT, 1'b1)
    // Lines 7 and 5 rise-sensitive, line 6 fall-sensitive, 3..0 outputs
    iwr(3'h3, 8'ha0);
    iwr(3'h6, 8'h0f);
    cpu.wr(`ADR_GENERAL_IO, 8'h5a);
    `CHK(IO_OUT, 8'h5a)
    `CHK(IO_OE_N, 8'hf0)
    IO_IN = 8'he0;
    rchk(`ADR_GENERAL_IO, 8'hea);
    rchk(`ADR_PEND_HIGH, 8'h80);
    rchk(`ADR_PEND_LOW, 8'h80);
    IO_IN = 8'h00;
    rchk(`ADR_PEND_HIGH, 8'hc0);
    for (int k = 0; k < 3; k++) begin
      cpu.ack(d, oe);
      `CHK(d, line_vec[k])
    end
    ev(16'h2000);
    NRST = 1'b0;
    cpu.tick(4);
    NRST = 1'b1;
    cpu.tick(4);
    rchk(`ADR_PEND_HIGH, 8'h00);
    rchk(`ADR_MASK_HIGH, 8'h00);
    `CHK(IO_OE_N, 8'hff)
    `CHK(IO_OUT, 8'h00)
    rchk(`ADR_TIMER_A_COUNT, 8'hb4);
    rchk(`ADR_SERIAL_DATA, 8'hf0);
    cpu.wr(`ADR_POINTER_VECTOR, 8'h01);
    rchk(`ADR_INDIRECT_DATA, 8'h41);
    give_verdict();
  end
endmodule
